// *** dv/sat_checker_properties.sv ***
// port-level checker for the auto-transfer block
// assumes the bench keeps divisor select 0 while the serial clock runs
`timescale 1ns/1ps
`include "sat_regs.vh"
module sat_checker (
	input wire        clk,
	input wire        rst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [17:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        sclkOut,
	input wire        sclkOe,
	input wire        dataOut,
	input wire        dataOe,
	input wire        strobeOut,
	input wire        strobeOe,
	input wire        transferDoneIrq
);
	logic        en;
	wire  [15:0] idx = paddr[17:2];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// unit enable as last committed over the bus
	always @(posedge clk) begin
		if (rst)
			en <= 1'b0;
		else if (psel && penable && pready && pwrite && idx == `SAT_IDX_MODE)
			en <= pwdata[`SAT_MODE_ENABLE];
	end
	chk_reset_pins: assert property ($fell(rst) |-> sclkOut && !dataOut && !sclkOe && !dataOe && !strobeOe)
		else $error("pins not idle after reset");
	chk_off_pins: assert property ((!en)[*2] |-> sclkOut && !dataOut)
		else $error("disabled pins wrong");
	chk_off_quiet: assert property ((!en)[*2] |-> !transferDoneIrq && !strobeOut)
		else $error("disabled unit active");
	chk_apb_answer: assert property (psel && penable && !$past(penable) |-> ##[1:2] pready)
		else $error("access not answered");
	chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error answer");
	chk_ptr_width: assert property (pready && !pwrite && idx == `SAT_IDX_ENDPTR |-> prdata[31:5] == 27'h0)
		else $error("end pointer too wide");
	chk_gap_width: assert property (pready && !pwrite && idx == `SAT_IDX_INTERVAL |-> prdata[31:6] == 26'h0)
		else $error("interval too wide");
	chk_sclk_half: assert property ($fell(sclkOut) |-> !sclkOut[*3] ##1 sclkOut)
		else $error("clock low phase wrong");
	chk_strobe_pulse: assert property ($rose(strobeOut) |-> strobeOut[*3] ##1 !strobeOut)
		else $error("strobe pulse wrong");
	cover property ($rose(transferDoneIrq));
	cover property (pslverr);
	cover property ($fell(sclkOut));
	cover property ($rose(strobeOut));
endmodule

bind sat_auto_transfer sat_checker chk (.*);

// *** dv/sat_peer.sv ***
// far-side peripheral model: takes data on clock rise, answers a fixed byte
// assumes clk far faster than the serial clock; msb arrives and leaves first
`timescale 1ns/1ps
module sat_peer (
	input  wire        clk,
	input  wire        rst,
	input  wire        sclk,
	input  wire        sdo,
	output logic       sdi,
	output logic [7:0] rxByte,
	output int         rxCount
);
	localparam logic [7:0] REPLY = 8'h35;
	logic       last;
	logic [7:0] sh;
	int         bits;
	// next reply bit set up just after each rise, well before the next one takes it
	assign sdi = REPLY[7 - bits];
	// edges found by sampling, so an unknown start never counts
	always @(posedge clk) begin
		last <= sclk;
		if (rst) begin
			bits <= 0;
			rxCount <= 0;
		end else if (sclk === 1'b1 && last === 1'b0) begin
			sh <= {sh[6:0], sdo};
			bits <= (bits + 1) % 8;
			if (bits == 7) begin
				rxByte <= {sh[6:0], sdo};
				rxCount <= rxCount + 1;
			end
		end
	end
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the auto-transfer block
// assumes sat_peer on the serial pins; slave clock and busy held idle
`timescale 1ns/1ps
`include "sat_regs.vh"
`define CHK(a, b) begin \
	samples_checked++; \
	if ((a) !== (b)) begin \
		num_errors++; \
		$display("Error %0t: %h vs %h", $time, a, b); \
	end \
end
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0;
	logic [7:0]  rd;
	logic        er;
	logic [7:0]  rxByte;
	int          rxCount, num_errors, samples_checked, c0, c1, n;
	wire  [31:0] prdata;
	wire         pready, pslverr, sclkOut, sclkOe, dataOut, dataOe, strobeOut, strobeOe, irq, sdi;
	// {write, index, data, expected read}
	logic [32:0] rows [10] = '{33'h0ff2e00ff, 33'h0ff900000, 33'h0ff940000, 33'h0ff950000,
		33'h0ff970000, 33'h1ff2e00c0, 33'h1ff909f9e, 33'h1ff941f1f, 33'h1ff953f3f, 33'h1ff975500};

	sat_auto_transfer uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sclkIn(1'b1), .sclkOut(sclkOut), .sclkOe(sclkOe), .dataIn(sdi), .dataOut(dataOut),
		.dataOe(dataOe), .strobeOut(strobeOut), .strobeOe(strobeOe), .busyIn(1'b0),
		.transferDoneIrq(irq));
	sat_peer peer (.clk(clk), .rst(rst), .sclk(sclkOut), .sdo(dataOut), .sdi(sdi), .rxByte(rxByte),
		.rxCount(rxCount));

	initial
		forever #12.5 clk = ~clk;

	// verdict and end of run
	task results;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one bus transfer; an edge first so psel is never set twice at once
	task apb(input logic w, input logic [15:0] i, input logic [7:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			results();
		end
	endtask

	// bounded wait: done pulse when n is 0, else n bytes at the peer
	task waitOn(input int n, output int c);
		c = 0;
		while ((n == 0 ? irq !== 1'b1 : rxCount < n) && c < 5000) begin
			@(posedge clk);
			c++;
		end
		if (n == 0 ? irq !== 1'b1 : rxCount < n) begin
			num_errors++;
			results();
		end
	endtask

	// single byte; cycle count to the done pulse shows the gap
	task sbyte(input logic [7:0] iv, output int c);
		apb(1'b1, `SAT_IDX_INTERVAL, iv);
		apb(1'b1, `SAT_IDX_SHIFT, 8'ha5);
		waitOn(0, c);
		`CHK(rxByte, 8'ha5)
		apb(1'b0, `SAT_IDX_SHIFT, 8'h00);
		`CHK(rd, 8'h35)
	endtask

	// table first, then gaps, auto, repeat, reset
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[k]) begin
			if (rows[k][32])
				apb(1'b1, rows[k][31:16], rows[k][15:8]);
			apb(1'b0, rows[k][31:16], 8'h00);
			`CHK(rd, rows[k][7:0])
		end
		apb(1'b0, 16'h0000, 8'h00);
		`CHK(er, 1'b1)
		apb(1'b1, `SAT_IDX_DIVISOR, 8'h00);
		apb(1'b1, `SAT_IDX_PORTDIR, 8'hcb);
		apb(1'b1, `SAT_IDX_MODE, 8'h9c);
		`CHK({sclkOe, dataOe, strobeOe}, 3'h7)
		sbyte(8'h00, c0);
		sbyte(8'h03, c1);
		`CHK(c1 - c0, 18)
		apb(1'b1, `SAT_IDX_STATUS, 8'h20);
		sbyte(8'h00, c1);
		`CHK(c1 - c0, 12)
		apb(1'b1, `SAT_IDX_STATUS, 8'h10);
		sbyte(8'h00, c1);
		`CHK(c1 - c0, 6)
		// lsb first: both directions reversed
		apb(1'b1, `SAT_IDX_MODE, 8'h9e);
		apb(1'b1, `SAT_IDX_SHIFT, 8'h12);
		waitOn(0, c1);
		`CHK(rxByte, 8'h48)
		apb(1'b0, `SAT_IDX_SHIFT, 8'h00);
		`CHK(rd, 8'hac)
		apb(1'b1, `SAT_IDX_STATUS, 8'h20);
		for (int k = 0; k < 3; k++)
			apb(1'b1, 16'(`SAT_IDX_BUF_BASE + k), 8'(8'h11 * (k + 1)));
		apb(1'b1, `SAT_IDX_ENDPTR, 8'h02);
		apb(1'b1, `SAT_IDX_MODE, 8'hdc);
		n = rxCount;
		apb(1'b1, `SAT_IDX_TRIGGER, 8'h01);
		apb(1'b0, `SAT_IDX_STATUS, 8'h00);
		`CHK(rd, 8'h21)
		waitOn(0, c1);
		`CHK(rxCount - n, 3)
		`CHK(rxByte, 8'h33)
		apb(1'b0, `SAT_IDX_BUF_BASE, 8'h00);
		`CHK(rd, 8'h35)
		apb(1'b0, `SAT_IDX_ADDRCNT, 8'h00);
		`CHK(rd, 8'h02)
		apb(1'b0, `SAT_IDX_STATUS, 8'h00);
		`CHK(rd, 8'h20)
		apb(1'b1, `SAT_IDX_ENDPTR, 8'h01);
		// receive off so the buffer keeps what is sent and the wrap shows
		apb(1'b1, `SAT_IDX_BUF_BASE, 8'h11);
		apb(1'b1, `SAT_IDX_MODE, 8'hf8);
		n = rxCount;
		apb(1'b1, `SAT_IDX_TRIGGER, 8'h01);
		waitOn(n + 1, c1);
		`CHK(rxByte, 8'h11)
		waitOn(n + 2, c1);
		`CHK(rxByte, 8'h35)
		waitOn(n + 3, c1);
		`CHK(rxByte, 8'h11)
		apb(1'b1, `SAT_IDX_TRIGGER, 8'h02);
		waitOn(0, c1);
		apb(1'b1, `SAT_IDX_MODE, 8'h00);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `SAT_IDX_PORTDIR, 8'h00);
		`CHK(rd, 8'hff)
		results();
	end
endmodule

// *** logic/sat_auto_transfer.v ***
// automatic multi-byte control of the clocked three-wire serial unit
// assumes an APB master on clk; serial pins come from outside and are synchronised here
`timescale 1ns/1ps
`include "sat_regs.vh"

module sat_auto_transfer #(
	parameter BUF_DEPTH = 32,
	parameter ADDR_W    = 5
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [17:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        sclkIn,
	output reg         sclkOut,
	output reg         sclkOe,
	input  wire        dataIn,
	output reg         dataOut,
	output reg         dataOe,
	output reg         strobeOut,
	output reg         strobeOe,
	input  wire        busyIn,
	output reg         transferDoneIrq
);

	// engine states
	localparam ST_IDLE  = 2'h0;
	localparam ST_SHIFT = 2'h1;
	localparam ST_GAP   = 2'h2;

	// bus order reversal for lsb-first, used on load and on store
	function [7:0] rev8;
		input [7:0] v;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1)
				rev8[i] = v[7 - i];
		end
	endfunction

	// half period of the serial clock in clk cycles, per divisor select
	function [4:0] halfDiv;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: halfDiv = `SAT_HALF_DIV0;
				2'h1: halfDiv = `SAT_HALF_DIV1;
				2'h2: halfDiv = `SAT_HALF_DIV2;
				default: halfDiv = `SAT_HALF_DIV3;
			endcase
		end
	endfunction

	// register file and engine state
	reg  [7:0]        portDir;
	reg  [7:0]        modeReg;
	reg  [1:0]        divSel;
	reg  [ADDR_W-1:0] endPtr;
	reg  [5:0]        interval;
	reg  [ADDR_W-1:0] addrCnt;
	reg               strobeEn;
	reg               busyEn;
	reg               active;
	reg               startReq;
	reg               stopReq;
	reg  [7:0]        rxData;
	reg  [7:0]        bufMem [0:BUF_DEPTH-1];
	reg  [1:0]        state;
	reg  [2:0]        bitCnt;
	reg  [7:0]        shiftReg;
	reg  [5:0]        gapCnt;
	reg  [4:0]        divCnt;
	reg               phase;
	reg  [2:0]        sclkSync;
	reg  [1:0]        dinSync;
	reg  [1:0]        busySync;

	// mode fields and bus decode
	wire        unitOn   = modeReg[`SAT_MODE_ENABLE];
	wire        autoOn   = modeReg[`SAT_MODE_AUTO];
	wire        master   = modeReg[`SAT_MODE_MASTER];
	wire        lsbFirst = modeReg[`SAT_MODE_ORDER];
	wire [15:0] regIdx   = paddr[17:2];
	wire        busWr    = psel & penable & pready & pwrite;
	wire        busSetup = psel & penable & ~pready;
	// buffer window compared at full index width
	wire        bufHit   = ((regIdx >> ADDR_W) == (`SAT_IDX_BUF_BASE >> ADDR_W));
	wire [ADDR_W-1:0] bufIdx = regIdx[ADDR_W-1:0];

	// serial clock edges: own divider as master, synchronised pin as slave
	wire [4:0] half    = halfDiv(divSel);
	wire       divWrap = (divCnt == half - 5'h01);
	wire       sFall   = master ? (divWrap & phase) : (sclkSync[2] & ~sclkSync[1]);
	wire       sRise   = master ? (divWrap & ~phase) : (~sclkSync[2] & sclkSync[1]);

	// strobe and busy gaps win over a shorter interval
	wire [5:0] minGap  = strobeEn ? `SAT_GAP_STROBE : (busyEn ? `SAT_GAP_BUSY : 6'h00);
	wire [5:0] gapLen  = ~master ? 6'h00 : ((interval > minGap) ? interval : minGap);
	// a gap only closes on the high phase, so the next byte opens with a fall;
	// this matters when a busy release lands in mid-period
	wire       gapDone = (gapCnt >= gapLen) & ~(busyEn & busySync[1]) & phase;
	wire       atEnd   = (addrCnt == endPtr);

	// start conditions; a running engine ignores a second start
	wire autoStart   = busWr & (regIdx == `SAT_IDX_TRIGGER) & pwdata[`SAT_TRIG_START] & autoOn & ~active;
	wire singleStart = busWr & (regIdx == `SAT_IDX_SHIFT) & ~autoOn & ~active;

	// pin synchronisers; first stage is read only by the second
	always @(posedge clk) begin
		if (rst) begin
			sclkSync <= 3'h7;
			dinSync  <= 2'h0;
			busySync <= 2'h0;
		end else begin
			sclkSync <= {sclkSync[1:0], sclkIn};
			dinSync  <= {dinSync[0], dataIn};
			busySync <= {busySync[0], busyIn};
		end
	end

	// apb slave: one wait state, answer registered
	always @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= busSetup;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			// decode on the first access cycle so the answer stands with pready
			if (busSetup) begin
				case (regIdx)
					`SAT_IDX_PORTDIR:  prdata <= {24'h0, portDir};
					`SAT_IDX_SHIFT:    prdata <= {24'h0, rxData};
					`SAT_IDX_MODE:     prdata <= {24'h0, modeReg[7:1], 1'b0};
					`SAT_IDX_STATUS:   prdata <= {26'h0, strobeEn, busyEn, 3'h0, active};
					`SAT_IDX_TRIGGER:  prdata <= {30'h0, stopReq, startReq};
					`SAT_IDX_DIVISOR:  prdata <= {30'h0, divSel};
					`SAT_IDX_ENDPTR:   prdata <= {27'h0, endPtr};
					`SAT_IDX_INTERVAL: prdata <= {26'h0, interval};
					`SAT_IDX_ADDRCNT:  prdata <= {27'h0, addrCnt};
					default: begin
						if (bufHit)
							prdata <= {24'h0, bufMem[bufIdx]};
						else
							pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// configuration registers
	always @(posedge clk) begin
		if (rst) begin
			portDir  <= `SAT_RST_PORTDIR;
			modeReg  <= `SAT_RST_MODE;
			divSel   <= `SAT_RST_DIVISOR;
			endPtr   <= {ADDR_W{1'b0}};
			interval <= 6'h00;
			strobeEn <= 1'b0;
			busyEn   <= 1'b0;
		end else if (busWr) begin
			case (regIdx)
				`SAT_IDX_PORTDIR:  portDir  <= {2'h3, pwdata[5:0]};
				`SAT_IDX_MODE:     modeReg  <= {pwdata[7:1], 1'b0};
				`SAT_IDX_STATUS: begin
					strobeEn <= pwdata[`SAT_ST_STROBEEN];
					busyEn   <= pwdata[`SAT_ST_BUSYEN];
				end
				`SAT_IDX_DIVISOR:  divSel   <= pwdata[1:0];
				`SAT_IDX_ENDPTR:   endPtr   <= pwdata[ADDR_W-1:0];  // upper bits dropped
				`SAT_IDX_INTERVAL: interval <= pwdata[5:0];
				// a shift data write is taken by the engine directly
				default: ;
			endcase
		end
	end

	// buffer ram; the engine store wins a same-cycle collision with the bus
	always @(posedge clk) begin
		if (unitOn & autoOn & (state == ST_SHIFT) & sRise & (bitCnt == 3'h7) & modeReg[`SAT_MODE_RX])
			bufMem[addrCnt] <= lsbFirst ? rev8({shiftReg[6:0], dinSync[1]}) : {shiftReg[6:0], dinSync[1]};
		else if (busWr & bufHit)
			bufMem[bufIdx] <= pwdata[7:0];
	end

	// master clock divider, runs only while a byte or gap is in flight
	always @(posedge clk) begin
		if (rst | ~unitOn | (state == ST_IDLE)) begin
			divCnt <= 5'h00;
			phase  <= 1'b1;
		end else if (divWrap) begin
			divCnt <= 5'h00;
			phase  <= ~phase;
		end else begin
			divCnt <= divCnt + 5'h01;
		end
	end

	// transfer engine
	always @(posedge clk) begin
		if (rst | ~unitOn) begin
			state           <= ST_IDLE;
			active          <= 1'b0;
			startReq        <= 1'b0;
			stopReq         <= 1'b0;
			bitCnt          <= 3'h0;
			shiftReg        <= 8'h00;
			gapCnt          <= 6'h00;
			transferDoneIrq <= 1'b0;
			sclkOut         <= 1'b1;
			dataOut         <= 1'b0;
			strobeOut       <= 1'b0;
			// address counter survives a disable so the stop position stays readable
			if (rst) begin
				addrCnt <= {ADDR_W{1'b0}};
				rxData  <= 8'h00;
			end
		end else begin
			transferDoneIrq <= 1'b0;
			if (busWr & (regIdx == `SAT_IDX_TRIGGER) & autoOn & pwdata[`SAT_TRIG_STOP] & active)
				stopReq <= 1'b1;
			case (state)
				ST_IDLE: begin
					sclkOut   <= 1'b1;
					strobeOut <= 1'b0;
					if (autoStart) begin
						addrCnt  <= {ADDR_W{1'b0}};
						shiftReg <= lsbFirst ? rev8(bufMem[0]) : bufMem[0];
						startReq <= 1'b1;
						active   <= 1'b1;
						bitCnt   <= 3'h0;
						state    <= ST_SHIFT;
					end else if (singleStart) begin
						shiftReg <= lsbFirst ? rev8(pwdata[7:0]) : pwdata[7:0];
						active   <= 1'b1;
						bitCnt   <= 3'h0;
						dataOut  <= 1'b0;
						state    <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (master)
						sclkOut <= sFall ? 1'b0 : (sRise ? 1'b1 : sclkOut);
					// data changes on the falling edge, sampled on the rising one
					if (sFall)
						dataOut <= modeReg[`SAT_MODE_TX] & shiftReg[7];
					// eighth rising edge closes the byte and opens the gap
					if (sRise) begin
						shiftReg <= {shiftReg[6:0], dinSync[1]};
						bitCnt   <= bitCnt + 3'h1;
						if (bitCnt == 3'h7) begin
							if (~autoOn)
								rxData <= lsbFirst ? rev8({shiftReg[6:0], dinSync[1]})
								                   : {shiftReg[6:0], dinSync[1]};
							gapCnt    <= 6'h00;
							strobeOut <= strobeEn & master;
							state     <= ST_GAP;
						end
					end
				end
				ST_GAP: begin
					sclkOut <= 1'b1;
					// strobe drops at the first falling edge of the gap
					if (sFall)
						strobeOut <= 1'b0;
					// whole serial clocks, counted at their rising edge, so a gap
					// of n lasts exactly n periods
					if (sRise & (gapCnt != 6'h3f))
						gapCnt <= gapCnt + 6'h01;
					if (gapDone) begin
						bitCnt <= 3'h0;
						if (autoOn & ~stopReq & ~atEnd) begin
							addrCnt  <= addrCnt + 1'b1;
							shiftReg <= lsbFirst ? rev8(bufMem[addrCnt + 1'b1]) : bufMem[addrCnt + 1'b1];
							state    <= ST_SHIFT;
						end else if (autoOn & ~stopReq & modeReg[`SAT_MODE_REPEAT]) begin
							addrCnt  <= {ADDR_W{1'b0}};
							shiftReg <= lsbFirst ? rev8(bufMem[0]) : bufMem[0];
							state    <= ST_SHIFT;
						end else begin
							// stop position stays in the address counter
							active          <= 1'b0;
							startReq        <= 1'b0;
							stopReq         <= 1'b0;
							transferDoneIrq <= 1'b1;
							state           <= ST_IDLE;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// output enables follow the direction register, 0 drives the pin
	always @(posedge clk) begin
		if (rst) begin
			sclkOe   <= 1'b0;
			dataOe   <= 1'b0;
			strobeOe <= 1'b0;
		end else begin
			sclkOe   <= ~portDir[`SAT_PIN_CLK];
			dataOe   <= ~portDir[`SAT_PIN_DOUT];
			strobeOe <= ~portDir[`SAT_PIN_STROBE];
		end
	end

endmodule

// *** logic/sat_regs.vh ***
// register indices, field positions, reset values and clock divisors
// assumes APB byte address = 4 * register index, 32-bit aligned words
`ifndef SAT_REGS_VH
`define SAT_REGS_VH
`define SAT_IDX_PORTDIR   16'hff2e
`define SAT_IDX_SHIFT     16'hff8f
`define SAT_IDX_MODE      16'hff90
`define SAT_IDX_STATUS    16'hff91
`define SAT_IDX_TRIGGER   16'hff92
`define SAT_IDX_DIVISOR   16'hff93
`define SAT_IDX_ENDPTR    16'hff94
`define SAT_IDX_INTERVAL  16'hff95
`define SAT_IDX_ADDRCNT   16'hff97
`define SAT_IDX_BUF_BASE  16'hfa00
`define SAT_RST_PORTDIR   8'hff
`define SAT_RST_MODE      8'h00
`define SAT_RST_DIVISOR   2'h3
`define SAT_MODE_ENABLE   7
`define SAT_MODE_AUTO     6
`define SAT_MODE_REPEAT   5
`define SAT_MODE_MASTER   4
`define SAT_MODE_TX       3
`define SAT_MODE_RX       2
`define SAT_MODE_ORDER    1
`define SAT_ST_ACTIVE     0
`define SAT_ST_BUSYEN     4
`define SAT_ST_STROBEEN   5
`define SAT_TRIG_START    0
`define SAT_TRIG_STOP     1
`define SAT_PIN_BUSY      1
`define SAT_PIN_CLK       2
`define SAT_PIN_DIN       3
`define SAT_PIN_DOUT      4
`define SAT_PIN_STROBE    5
`define SAT_HALF_DIV0     5'h03
`define SAT_HALF_DIV1     5'h04
`define SAT_HALF_DIV2     5'h0c
`define SAT_HALF_DIV3     5'h10
`define SAT_GAP_STROBE    6'h02
`define SAT_GAP_BUSY      6'h01
`endif
